// *** hw/filter_route.sv ***
// routing register for filters 4 to 7 with apb access and write selects
//
// Operation
// RULE_01 - filter 7 destination from bits 15:12
// RULE_02 - filter 6 destination from bits 11:8
// RULE_03 - filter 5 destination from bits 7:4
// RULE_04 - filter 4 destination from bits 3:0
// RULE_05 - code all ones routes to receive fifo
// RULE_06 - codes 0 to 14 select that buffer
// RULE_07 - fields read/write, reset to zero
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module filter_route (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  filter_hit,
   output logic [14:0]      buf_write_sel,
   output logic             fifo_write_sel,
   output logic [15:0]      filter4to7_buffer_pointer
);
   rx_route_pkg::state_t s_r;
   rx_route_pkg::state_t s_nxt;

   route_if rif [rx_route_pkg::NUM_FILTERS] ();

   logic [3:0] dest_of [rx_route_pkg::NUM_FILTERS];
   // one decoder per filter keeps the four routes identical
   always_comb begin
      dest_of[0] = s_r.pointer_r[rx_route_pkg::F4_LSB +: 4]; // RULE_04
      dest_of[1] = s_r.pointer_r[rx_route_pkg::F5_LSB +: 4]; // RULE_03
      dest_of[2] = s_r.pointer_r[rx_route_pkg::F6_LSB +: 4]; // RULE_02
      dest_of[3] = s_r.pointer_r[rx_route_pkg::F7_LSB +: 4]; // RULE_01
   end

   logic [14:0] bsel [rx_route_pkg::NUM_FILTERS];
   logic [3:0]  fsel;
   genvar g;
   generate
      for (g = 0; g < rx_route_pkg::NUM_FILTERS; g++) begin : g_dec
         assign rif[g].hit  = filter_hit[g];
         assign rif[g].dest = dest_of[g];
         assign bsel[g]     = rif[g].buf_sel;
         assign fsel[g]     = rif[g].fifo_sel;
         dest_decoder u_dec (
            .r (rif[g])
         );
      end
   endgenerate

   logic access;
   logic hit_any;
   assign access  = psel & penable & ~s_r.pready_r;
   assign hit_any = |filter_hit;

   always_comb begin
      s_nxt           = s_r;
      s_nxt.pready_r  = 1'b0;
      s_nxt.pslverr_r = 1'b0;
      // several hits at once merge; the filter logic normally hits one
      s_nxt.buf_we_r  = bsel[0] | bsel[1] | bsel[2] | bsel[3];
      s_nxt.fifo_we_r = |fsel;
      if (hit_any) begin
         s_nxt.last_valid_r = 1'b1;
         for (int i = rx_route_pkg::NUM_FILTERS - 1; i >= 0; i--) begin
            if (filter_hit[i]) begin
               s_nxt.last_dest_r = dest_of[i];
            end
         end
      end
      if (access) begin
         s_nxt.pready_r = 1'b1;
         s_nxt.prdata_r = '0;
         if (paddr == rx_route_pkg::ADDR_POINTER) begin
            if (pwrite) begin
               if (pstrb[0]) begin
                  s_nxt.pointer_r[7:0] = pwdata[7:0]; // RULE_07
               end
               if (pstrb[1]) begin
                  s_nxt.pointer_r[15:8] = pwdata[15:8]; // RULE_07
               end
            end else begin
               s_nxt.prdata_r[15:0] = s_r.pointer_r; // RULE_07
            end
         end else if (paddr == rx_route_pkg::ADDR_STATUS) begin
            if (!pwrite) begin
               s_nxt.prdata_r[4:0] = {s_r.last_valid_r, s_r.last_dest_r};
            end
         end else begin
            s_nxt.pslverr_r = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r           <= '0;
         s_r.pointer_r <= rx_route_pkg::POINTER_RESET; // RULE_07
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata                    = s_r.prdata_r;
   assign pready                    = s_r.pready_r;
   assign pslverr                   = s_r.pslverr_r;
   assign buf_write_sel             = s_r.buf_we_r;
   assign fifo_write_sel            = s_r.fifo_we_r;
   assign filter4to7_buffer_pointer = s_r.pointer_r;

   a_f7_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
      (filter_hit == 4'h8 && s_r.pointer_r[15:12] != 4'hF)
      |=> buf_write_sel[$past(s_r.pointer_r[15:12])])
      else $error("filter 7 hit missed its buffer");
   a_f6_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
      (filter_hit == 4'h4 && s_r.pointer_r[11:8] != 4'hF)
      |=> buf_write_sel[$past(s_r.pointer_r[11:8])])
      else $error("filter 6 hit missed its buffer");
   a_f5_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
      (filter_hit == 4'h2 && s_r.pointer_r[7:4] != 4'hF)
      |=> buf_write_sel[$past(s_r.pointer_r[7:4])])
      else $error("filter 5 hit missed its buffer");
   a_f4_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
      (filter_hit == 4'h1 && s_r.pointer_r[3:0] != 4'hF)
      |=> buf_write_sel[$past(s_r.pointer_r[3:0])])
      else $error("filter 4 hit missed its buffer");
   a_fifo_route: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      (filter_hit == 4'h1 && s_r.pointer_r[3:0] == 4'hF)
      |=> fifo_write_sel && buf_write_sel == 15'h0000)
      else $error("fifo code did not route to fifo");
   a_buf_onehot: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
      ($onehot(filter_hit) && !(|fsel)) |=> $onehot(buf_write_sel)
      && !fifo_write_sel)
      else $error("buffer select not one-hot");
   a_no_hit_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
      (filter_hit == 4'h0) |=> buf_write_sel == 15'h0000 && !fifo_write_sel)
      else $error("select without hit");
   a_write_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (access && pwrite && paddr == rx_route_pkg::ADDR_POINTER
       && pstrb[1:0] == 2'h3)
      |=> filter4to7_buffer_pointer == $past(pwdata[15:0]))
      else $error("pointer write not stored");
   a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held too long");
   c_fifo: cover property (@(posedge pclk) disable iff (!presetn)
      fifo_write_sel);
   c_buf14: cover property (@(posedge pclk) disable iff (!presetn)
      buf_write_sel[14]);
   c_write: cover property (@(posedge pclk) disable iff (!presetn)
      access && pwrite);
   c_merge: cover property (@(posedge pclk) disable iff (!presetn)
      filter_hit == 4'hF);
   c_partial: cover property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && pstrb[1:0] == 2'h1);

   // bus side: one wait state, answer stands a single cycle
   a_access_ready: assert property (@(posedge pclk) disable iff (!presetn)
      access
      |=> pready)
      else $error("access phase not answered");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (access && paddr != rx_route_pkg::ADDR_POINTER
       && paddr != rx_route_pkg::ADDR_STATUS)
      |=> pslverr)
      else $error("unmapped access without error");
   a_err_no_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (access && pwrite && paddr != rx_route_pkg::ADDR_POINTER)
      |=> $stable(filter4to7_buffer_pointer))
      else $error("foreign write changed pointer");
   a_read_value: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (access && !pwrite && paddr == rx_route_pkg::ADDR_POINTER)
      |=> prdata == {16'h0000, $past(s_r.pointer_r)})
      else $error("pointer read wrong");
   a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == rx_route_pkg::ADDR_STATUS)
      |=> prdata == {27'h0000000, $past(s_r.last_valid_r),
                     $past(s_r.last_dest_r)})
      else $error("status read wrong");
   a_byte_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (access && pwrite && paddr == rx_route_pkg::ADDR_POINTER
       && pstrb[1:0] == 2'h1)
      |=> filter4to7_buffer_pointer == {$past(s_r.pointer_r[15:8]),
                                        $past(pwdata[7:0])})
      else $error("low byte write wrong");
   a_byte_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      (access && pwrite && paddr == rx_route_pkg::ADDR_POINTER
       && pstrb[1:0] == 2'h2)
      |=> filter4to7_buffer_pointer == {$past(pwdata[15:8]),
                                        $past(s_r.pointer_r[7:0])})
      else $error("high byte write wrong");
   a_no_access_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
      !access |=> $stable(filter4to7_buffer_pointer))
      else $error("pointer changed without access");
   a_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error without ready");

   // route side: the fifo code must never leak into a buffer select
   a_f7_fifo: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      (filter_hit == 4'h8 && s_r.pointer_r[15:12] == 4'hF)
      |=> fifo_write_sel && buf_write_sel == 15'h0000)
      else $error("filter 7 fifo code missed fifo");
   a_f6_fifo: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      (filter_hit == 4'h4 && s_r.pointer_r[11:8] == 4'hF)
      |=> fifo_write_sel && buf_write_sel == 15'h0000)
      else $error("filter 6 fifo code missed fifo");
   a_f5_fifo: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      (filter_hit == 4'h2 && s_r.pointer_r[7:4] == 4'hF)
      |=> fifo_write_sel && buf_write_sel == 15'h0000)
      else $error("filter 5 fifo code missed fifo");
   a_fifo_no_hit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
      fifo_write_sel
      |-> $past(|filter_hit))
      else $error("fifo select without hit");
   a_seen_flag: assert property (@(posedge pclk) disable iff (!presetn)
      hit_any |=> s_r.last_valid_r)
      else $error("hit not recorded");
endmodule

// *** hw/rx_route_pkg.sv ***
// constants and types for the receive filter routing block
package rx_route_pkg;
   localparam int         NUM_FILTERS   = 4;
   localparam int         FIELD_W       = 4;
   localparam int         REG_W         = 16;
   localparam logic [11:0] ADDR_POINTER = 12'h000;
   localparam logic [11:0] ADDR_STATUS  = 12'h004;
   localparam logic [15:0] POINTER_RESET = 16'h0000;
   localparam logic [3:0]  DEST_FIFO    = 4'hF;
   localparam int         NUM_BUFFERS   = 15;
   localparam int         F4_LSB        = 0;
   localparam int         F5_LSB        = 4;
   localparam int         F6_LSB        = 8;
   localparam int         F7_LSB        = 12;
   typedef struct packed {
      logic [15:0] pointer_r;
      logic [14:0] buf_we_r;
      logic        fifo_we_r;
      logic [3:0]  last_dest_r;
      logic        last_valid_r;
      logic [31:0] prdata_r;
      logic        pready_r;
      logic        pslverr_r;
   } state_t;
endpackage

// *** hw/route_if.sv ***
// carrier between the top and one filter destination decoder
`timescale 1ns/100ps
interface route_if;
   logic        hit;
   logic [3:0]  dest;
   logic [14:0] buf_sel;
   logic        fifo_sel;
   modport top (output hit, output dest, input buf_sel, input fifo_sel);
   modport dec (input hit, input dest, output buf_sel, output fifo_sel);
endinterface

// *** hw/dest_decoder.sv ***
// decodes one filter's destination code into buffer and fifo selects
`timescale 1ns/100ps
module dest_decoder (
   route_if.dec r
);
   always_comb begin
      r.buf_sel  = '0;
      r.fifo_sel = 1'b0;
      if (r.hit) begin
         if (r.dest == rx_route_pkg::DEST_FIFO) begin
            r.fifo_sel = 1'b1; // RULE_05
         end else begin
            r.buf_sel[r.dest] = 1'b1; // RULE_06
         end
      end
   end
endmodule

// *** verif/filter_match_model.sv ***
// filter match source standing in for the acceptance filters
`timescale 1ns/100ps
module filter_match_model (
   input  wire logic       pclk,
   input  wire logic       fire,
   input  wire logic [3:0] pattern,
   output logic [3:0]      filter_hit
);
   // a hit lasts one cycle per accepted message, low when idle
   initial filter_hit = 4'h0;
   always @(posedge pclk) begin
      filter_hit <= fire ? pattern : 4'h0;
   end
endmodule

// *** verif/can_filter_buffer_pointer_test.sv ***
// self-checking bench for the filter routing register
`timescale 1ns/100ps
module can_filter_buffer_pointer_test;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, err, fire = 0;
   logic [3:0]  pattern = 4'h0, filter_hit, pstrb = 4'h3;
   int          last_d = 0;
   logic [14:0] buf_write_sel;
   logic        fifo_write_sel;
   logic [15:0] ptr_port, v;
   int          fails = 0, n_tests = 0, model_ptr = 0;
   always #12.5 pclk = ~pclk;
   filter_route u_filter_route (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .filter_hit(filter_hit), .buf_write_sel(buf_write_sel),
      .fifo_write_sel(fifo_write_sel), .filter4to7_buffer_pointer(ptr_port));
   filter_match_model u_filter_match_model (.pclk(pclk), .fire(fire),
      .pattern(pattern), .filter_hit(filter_hit));
   task automatic conclude();
      $display("mismatches %0d comparisons %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // pready and prdata are read at the edge, before that edge updates them
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      i = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50) begin
         fails++;
         conclude();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_ptr(input logic [15:0] w);
      apb(1'b1, rx_route_pkg::ADDR_POINTER, {16'h0, w});
      model_ptr = w;
      apb(1'b0, rx_route_pkg::ADDR_POINTER, 32'h0);
      chk(q, {16'h0, model_ptr[15:0]});
      chk({16'h0, ptr_port}, {16'h0, model_ptr[15:0]});
   endtask
   // expected selects packed as {fifo, buffers}: code 15 lands on bit 15
   task automatic hit(input logic [3:0] p);
      logic [15:0] e;
      e = 16'h0;
      for (int f = 0; f < 4; f++) begin
         if (p[f]) e[model_ptr[4*f +: 4]] = 1'b1;
      end
      for (int f = 3; f >= 0; f--) begin
         if (p[f]) last_d = model_ptr[4*f +: 4];
      end
      @(posedge pclk);
      pattern <= p;
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk({16'h0, fifo_write_sel, buf_write_sel}, {16'h0, e});
   endtask
   initial begin
      void'($urandom(32'h48591A30));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, rx_route_pkg::ADDR_POINTER, 32'h0);
      chk(q, 32'h0);
      hit(4'hF);
      for (int c = 0; c < 16; c++) begin
         v = {4'(c + 3), 4'(c + 2), 4'(c + 1), 4'(c)};
         wr_ptr(v);
         for (int f = 0; f < 4; f++) hit(4'(1 << f));
         hit(4'hF);
      end
      repeat (20) begin
         wr_ptr(16'($urandom));
         hit(4'($urandom));
      end
      apb(1'b0, rx_route_pkg::ADDR_STATUS, 32'h0);
      chk(q, {27'h0, 1'b1, last_d[3:0]});
      pstrb <= 4'h1;
      apb(1'b1, rx_route_pkg::ADDR_POINTER, 32'h5A5A);
      pstrb <= 4'h3;
      model_ptr[7:0] = 8'h5A;
      apb(1'b0, rx_route_pkg::ADDR_POINTER, 32'h0);
      chk(q, {16'h0, model_ptr[15:0]});
      apb(1'b1, 12'h008, 32'hFFFF);
      chk({31'h0, err}, 32'h1);
      chk({16'h0, ptr_port}, {16'h0, model_ptr[15:0]});
      conclude();
   end
endmodule
